// ### hw/ocsd_pkg.sv
// Constants for the overcurrent shutdown delay block
package ocsd_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] SHUTDOWN_DELAY_CONFIG_ADDR  = 8'h03;
	localparam logic [7:0] SHUTDOWN_DELAY_CONFIG_RESET = 8'h14;
	localparam logic [7:0] UNMAPPED_READ_VALUE         = 8'h00;

	// ----------------------------------------------------------------
	// Field layout of the delay byte
	// ----------------------------------------------------------------
	localparam int         COUNTER_RESET_BIT = 7;
	localparam int         TRIP_DELAY_MSB    = 6;
	localparam int         TRIP_DELAY_LSB    = 0;
	localparam int         TRIP_DELAY_WIDTH  = 7;

	// ----------------------------------------------------------------
	// Channels, comparator and timing
	// ----------------------------------------------------------------
	localparam int         CHANNEL_COUNT      = 4;
	localparam int         SAMPLE_WIDTH       = 8;
	localparam logic [7:0] LIMIT_DISABLED     = 8'hFF;
	localparam int         SAMPLE_PERIOD_MS   = 1;
	localparam int         COUNT_WIDTH        = 8;
	localparam logic [7:0] COUNT_MAX          = 8'hFF;

	typedef logic [COUNT_WIDTH-1:0] ocsd_count_t;

endpackage

// ### hw/ocsd_shutdown_delay.sv
// Per-channel shutdown qualification with delay configuration byte
//
// Contract
// - Read/write configuration byte at command code 03h sets delay and counter reset.
// - With bit 7 clear, the seven-bit delay field qualifies shutdown assertion.
// - With bit 7 set, counters held cleared and shutdown output forced low.
// - Delay code N means N ms, requiring N+1 consecutive over-threshold samples.
// - Each channel independently needs continuous consecutive breaches for the delay.
// - Delay zero asserts shutdown on the first breaching sample.
// - Delay 20 ms asserts shutdown only after 21 consecutive breaching samples.
// - Shutdown pin driven by a latch set when any channel qualifies.
// - Limit byte of all ones disables that channel's comparator entirely.
`timescale 1ns/100ps
`default_nettype none

module ocsd_shutdown_delay
	import ocsd_pkg::*;
(
	input  wire logic                                      sys_clk,
	input  wire logic                                      rst,
	input  wire logic [7:0]                                reg_addr,
	input  wire logic                                      reg_wr,
	input  wire logic [7:0]                                reg_wdata,
	input  wire logic                                      reg_rd,
	output logic      [7:0]                                reg_rdata,
	input  wire logic                                      sample_strobe,
	input  wire logic [CHANNEL_COUNT-1:0][SAMPLE_WIDTH-1:0] sample_data,
	input  wire logic [CHANNEL_COUNT-1:0][SAMPLE_WIDTH-1:0] overcurrent_limit_field,
	output logic      [CHANNEL_COUNT-1:0]                  trip_channel,
	output logic                                           power_cut_output
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic breach(input logic [SAMPLE_WIDTH-1:0] smp,
	                                input logic [SAMPLE_WIDTH-1:0] lim);
		breach = (lim != LIMIT_DISABLED) && (smp > lim);
	endfunction

	// ----------------------------------------------------------------
	// Configuration byte
	// ----------------------------------------------------------------
	logic [7:0]                  delay_config_q;
	logic                        counter_reset;
	ocsd_count_t                 trip_delay_code;
	ocsd_count_t                 count_q [CHANNEL_COUNT];
	logic [CHANNEL_COUNT-1:0]    qualify;
	logic [CHANNEL_COUNT-1:0]    trip_channel_q;
	logic                        power_cut_q;
	logic [7:0]                  reg_rdata_q;

	assign counter_reset   = delay_config_q[COUNTER_RESET_BIT];
	assign trip_delay_code = {1'b0, delay_config_q[TRIP_DELAY_MSB:TRIP_DELAY_LSB]};

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			delay_config_q <= SHUTDOWN_DELAY_CONFIG_RESET;
		end else if (reg_wr && reg_addr == SHUTDOWN_DELAY_CONFIG_ADDR) begin
			delay_config_q <= reg_wdata;
		end
	end

	// Registered read; answer lands the cycle after the read strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata_q <= UNMAPPED_READ_VALUE;
		end else if (reg_rd) begin
			if (reg_addr == SHUTDOWN_DELAY_CONFIG_ADDR) begin
				reg_rdata_q <= delay_config_q;
			end else begin
				reg_rdata_q <= UNMAPPED_READ_VALUE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Consecutive-sample counters
	// ----------------------------------------------------------------
	// Count holds breaches seen before this sample, so this one is count+1.
	// Compare with >= so lowering the delay mid-run still trips at once.
	always_comb begin
		for (int i = 0; i < CHANNEL_COUNT; i++) begin
			qualify[i] = sample_strobe && !counter_reset &&
			             breach(sample_data[i], overcurrent_limit_field[i]) &&
			             (count_q[i] >= trip_delay_code);
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < CHANNEL_COUNT; i++) begin
			if (rst || counter_reset) begin
				count_q[i] <= '0;
			end else if (sample_strobe) begin
				if (!breach(sample_data[i], overcurrent_limit_field[i])) begin
					count_q[i] <= '0;
				end else if (count_q[i] != COUNT_MAX) begin
					count_q[i] <= count_q[i] + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Shutdown latch
	// ----------------------------------------------------------------
	// Latch holds until the reset bit is written; a fault must not self-clear.
	always_ff @(posedge sys_clk) begin
		if (rst || counter_reset) begin
			power_cut_q <= 1'b0;
		end else if (|qualify) begin
			power_cut_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || counter_reset) begin
			trip_channel_q <= '0;
		end else begin
			trip_channel_q <= trip_channel_q | qualify;
		end
	end

	assign power_cut_output = power_cut_q;
	assign trip_channel     = trip_channel_q;
	assign reg_rdata        = reg_rdata_q;

endmodule

`default_nettype wire

// ### test/ocsd_power_model.sv
// Model of the power stage fed by the shutdown pin
`timescale 1ns/100ps
`default_nettype none
module ocsd_power_model (
	input  wire logic sys_clk,
	input  wire logic power_cut_output,
	output logic      rail_off
);
	// Rail switches one cycle late, like a slow gate driver
	always_ff @(posedge sys_clk) rail_off <= power_cut_output;
endmodule
`default_nettype wire

// ### test/ocsd_shutdown_delay_sva.sv
// Checker for the overcurrent shutdown delay block
`timescale 1ns/100ps
`default_nettype none
module ocsd_shutdown_delay_chk
	import ocsd_pkg::*;
(
	input wire logic                   sys_clk,
	input wire logic                   rst,
	input wire logic [7:0]             reg_addr,
	input wire logic                   reg_wr,
	input wire logic [7:0]             reg_wdata,
	input wire logic                   reg_rd,
	input wire logic [7:0]             reg_rdata,
	input wire logic                   sample_strobe,
	input wire logic [3:0][7:0]        sample_data,
	input wire logic [3:0][7:0]        overcurrent_limit_field,
	input wire logic [3:0]             trip_channel,
	input wire logic                   power_cut_output
);
	logic [7:0] cfg_q;
	wire logic  cw = reg_wr && reg_addr == 8'h03;
	always_ff @(posedge sys_clk) cfg_q <= rst ? 8'h14 : cw ? reg_wdata : cfg_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence cfg_read; reg_rd && reg_addr == 8'h03 && !reg_wr; endsequence
	a_read_back: assert property (cfg_read |=> reg_rdata == $past(cfg_q)) else $error("read");
	a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h03 |=> reg_rdata == 8'h00)
		else $error("unmapped");
	a_hold_clear: assert property (cfg_q[7] |=> !power_cut_output && trip_channel == 4'h0)
		else $error("clear");
	a_latch_holds: assert property (power_cut_output && !cfg_q[7] && !cw |=> power_cut_output)
		else $error("latch");
	a_trip_pin: assert property (trip_channel != 4'h0 |-> power_cut_output) else $error("pin");
	a_rise_strobe: assert property ($rose(power_cut_output) |-> $past(sample_strobe))
		else $error("rise");
	a_zero_delay: assert property (sample_strobe && cfg_q == 8'h00 && sample_data[0] >
		overcurrent_limit_field[0] && overcurrent_limit_field[0] != 8'hFF |=> power_cut_output)
		else $error("zero");
	a_off_channel: assert property ($rose(trip_channel[0]) |->
		$past(overcurrent_limit_field[0]) != 8'hFF) else $error("disabled");
endmodule
bind ocsd_shutdown_delay ocsd_shutdown_delay_chk chk (.*);
`default_nettype wire

// ### test/tb.sv
// Testbench for the overcurrent shutdown delay block
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sample_strobe = 0, pm = 0, rm = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, qr[$];
	logic [3:0][7:0] sample_data = 0, lim = {24'hFFFFFF, 8'h80};
	logic [3:0] trip;
	logic pwr, rail_off, e, qp[$];
	logic [7:0] codes[4] = '{8'h00, 8'h01, 8'h14, 8'h7F};
	int failures = 0, checks_done = 0, seed = 72, r;
	always #4 sys_clk = ~sys_clk;
	ocsd_shutdown_delay uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_strobe(sample_strobe),
		.sample_data(sample_data), .overcurrent_limit_field(lim), .trip_channel(trip),
		.power_cut_output(pwr));
	ocsd_power_model pmod (.sys_clk(sys_clk), .power_cut_output(pwr), .rail_off(rail_off));
	task stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] x, s);
		checks_done++;
		if (x !== s) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask
	always @(posedge sys_clk) begin
		pm <= sample_strobe;
		rm <= reg_rd;
	end
	always @(negedge sys_clk) begin
		if (pm) begin
			e = qp.pop_front();
			chk("power_cut_output", e, pwr);
			chk("trip_channel", {7'h0, e}, trip);
		end
		if (rm) chk("reg_rdata", qr.pop_front(), reg_rdata);
	end
	task wr(input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1;
		reg_addr <= 8'h03;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [7:0] a, x);
		@(posedge sys_clk);
		reg_rd <= 1;
		reg_addr <= a;
		qr.push_back(x);
		@(posedge sys_clk);
		reg_rd <= 0;
	endtask
	// Non-breach sample equals the limit: breach must be strictly above
	task samp(input logic b, x);
		@(posedge sys_clk);
		r = $random(seed);
		sample_strobe <= 1;
		sample_data <= {r[31:8], b ? (r[7:0] | 8'h81) : 8'h80};
		qp.push_back(x);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 0;
		rd(8'h03, 8'h14);
		rd(8'h05, 8'h00);
		foreach (codes[i]) begin
			wr(8'h80);
			wr(codes[i]);
			rd(8'h03, codes[i]);
			repeat (codes[i]) samp(1, 0);
			samp(0, 0);
			repeat (codes[i]) samp(1, 0);
			samp(1, 1);
			@(posedge sys_clk);
			sample_strobe <= 0;
		end
		wr(8'hFF);
		rd(8'h03, 8'hFF);
		repeat (3) samp(1, 0);
		@(posedge sys_clk);
		sample_strobe <= 0;
		repeat (3) @(posedge sys_clk);
		stop_test;
	end
	// Whole sequence needs well under 1000 cycles
	initial begin
		#100000;
		failures++;
		stop_test;
	end
endmodule
`default_nettype wire
